//--- dv/pbc_colour_ctrl_bench.sv
// Self-checking bench of the border and background colour control block.
// Assumes the host model and the bound checker are compiled first.
`define CHECK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module pbc_colour_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DK[4] = '{0, 10, 30, 50};
  localparam int LT[4] = '{60, 70, 80, 100};
  localparam int HU[4] = '{30, 50, 70, 100};
  logic clk = 1'b0, nrst = 1'b0, fs = 1'b0, hold = 1'b0, ok = 1'b0;
  logic [1:0] area = 2'h0;
  logic [2:0] chan = 3'h0;
  logic [7:0] shown = 8'h00;
  logic scl, sda, sda_oe, p_live, p_chr, lsv, hv, fac;
  logic [1:0] p_brt;
  logic [2:0] p_hue, lso, hco;
  logic [6:0] p_luma;
  logic [7:0] sh[5:9], ap[5:9];
  logic [31:0] seed = 32'hD6693C6E;
  int num_errors = 0, cmp_count = 0;

  always #10 clk = !clk;

  pbc_colour_ctrl i_pbc_colour_ctrl (.MCLK_I(clk), .NRST_I(nrst), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(), .SDA_OE_O(sda_oe), .FIELD_START_I(fs), .AREA_I(area), .CHAN_I(chan),
    .SHOWN_I(shown), .SUB_HOLD_I(hold), .LIVE_OK_I(ok), .PIX_LIVE_O(p_live),
    .PIX_BRT_O(p_brt), .PIX_HUE_O(p_hue), .PIX_LUMA_O(p_luma), .PIX_CHROMA_O(p_chr),
    .LIVE_SUB_O(lso), .LIVE_SUB_VALID_O(lsv), .HILITE_CH_O(hco), .HILITE_VALID_O(hv),
    .FACTORY_O(fac));
  pbc_host_model i_pbc_host_model (.clk_i(clk), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));

  function logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    return seed;
  endfunction
  function automatic logic [6:0] luma(input logic [1:0] b, input logic [2:0] h);
    if (h == 3'h0) return 7'(DK[b]);
    if (h == 3'h7) return 7'(LT[b]);
    return 7'(HU[b]);
  endfunction
  function automatic logic [13:0] pix();
    logic [7:0] v;
    v = ap[9];
    if (area == 2'h0) return 14'h2000;
    if (area == 2'h1 && ap[6][6]) v = ap[6];
    if (area == 2'h2) v = ap[7][6] ? ap[7] : ap[9];
    if (area == 2'h2 && ap[8][6] && chan == ap[5][6:4] && shown[chan]) v = ap[8];
    if (ap[9][7:6] == 2'h3) v = ap[9];
    if (!v[6]) return {ok, 13'h0000};
    return {1'b0, v[5:4], v[2:0], luma(v[5:4], v[2:0]), v[2:0] != 3'h0 && v[2:0] != 3'h7};
  endfunction

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] o, input logic [7:0] v);
    int n;
    i_pbc_host_model.wr(o, v, n);
    `CHECK("write ack", 0, n)
    if (o >= 8'h05 && o <= 8'h09) sh[o] = v & (o == 8'h09 ? 8'hF7 : 8'h77);
  endtask
  task automatic rreg(input logic [7:0] o, input logic [7:0] e);
    logic [7:0] q;
    int n;
    i_pbc_host_model.rd(o, q, n);
    `CHECK("read ack", 0, n)
    `CHECK("read data", e, q)
  endtask
  task automatic field();
    fs <= 1'b1;
    @(posedge clk);
    fs <= 1'b0;
    ap = sh;
  endtask
  // At least half the channels drawn hit the highlight pick, so that border is reached often
  task automatic burst(input int n);
    repeat (n) begin
      @(posedge clk);
      area <= 2'(rnd() % 4);
      chan <= rnd() % 2 ? ap[5][6:4] : 3'(rnd());
      shown <= 8'(rnd());
      hold <= 1'(rnd());
      ok <= (rnd() % 4) != 0;
      @(posedge clk);
      #1;
      `CHECK("pixel", pix(), {p_live, p_brt, p_hue, p_luma, p_chr})
      `CHECK("picks", {ap[5][2:0], !hold && shown[ap[5][2:0]], ap[5][6:4],
        ap[8][6] && shown[ap[5][6:4]], ap[9][7] && ap[9][6]}, {lso, lsv, hco, hv, fac})
    end
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int i = 5; i <= 9; i++) sh[i] = 8'h00;
    ap = sh;
    for (int i = 5; i <= 9; i++) rreg(8'(i), 8'h00);
    burst(4);
    $display("test reset done");
    for (int i = 5; i <= 11; i++) wreg(8'(i), 8'hFF);
    for (int i = 5; i <= 11; i++) rreg(8'(i), i <= 9 ? sh[i] : 8'h00);
    burst(6);
    field();
    burst(20);
    $display("test masks and factory done");
    for (int c = 0; c < 32; c++) begin
      wreg(8'h06, 8'(8'h40 + (c / 8) * 16 + c % 8));
      wreg(8'h09, 8'(8'h40 + (c / 8) * 16 + c % 8));
      field();
      burst(4);
    end
    $display("test colour table done");
    wreg(8'h05, 8'h53);
    wreg(8'h07, 8'h00);
    wreg(8'h08, 8'h71);
    field();
    burst(30);
    wreg(8'h08, 8'h31);
    field();
    burst(30);
    $display("test highlight done");
    for (int k = 0; k < 10; k++) begin
      for (int i = 5; i <= 9; i++) wreg(8'(i), 8'(rnd()));
      burst(4);
      field();
      burst(40);
    end
    $display("test random done");
    print_verdict();
  end
endmodule

//--- dv/pbc_colour_ctrl_chk.sv
// Port assertions of the colour control block.
// Assumes one clock domain; bound to the top module below.
module pbc_colour_ctrl_chk #(
  parameter int CHANNELS = 8
) (
  input wire logic MCLK_I,
  input wire logic NRST_I,
  input wire logic FIELD_START_I,
  input wire logic [1:0] AREA_I,
  input wire logic SUB_HOLD_I,
  input wire logic LIVE_OK_I,
  input wire logic PIX_LIVE_O,
  input wire logic [1:0] PIX_BRT_O,
  input wire logic [2:0] PIX_HUE_O,
  input wire logic [6:0] PIX_LUMA_O,
  input wire logic PIX_CHROMA_O,
  input wire logic [2:0] LIVE_SUB_O,
  input wire logic LIVE_SUB_VALID_O,
  input wire logic [2:0] HILITE_CH_O,
  input wire logic HILITE_VALID_O,
  input wire logic FACTORY_O
);
  default clocking tick @(posedge MCLK_I); endclocking
  default disable iff (!NRST_I);

  AST_HOLD_STOPS_LIVE: assert property (
    LIVE_SUB_VALID_O |-> !$past(SUB_HOLD_I)) else $error("live sub valid while held");
  AST_LIVE_NO_COLOUR: assert property (
    PIX_LIVE_O |-> {PIX_BRT_O, PIX_HUE_O, PIX_LUMA_O, PIX_CHROMA_O} == 13'h0000)
    else $error("colour on live pixel");
  AST_HUE_FLAG: assert property (
    !PIX_LIVE_O |-> PIX_CHROMA_O == (PIX_HUE_O inside {[3'h1:3'h6]}))
    else $error("chroma flag wrong");
  AST_DARK_LADDER: assert property (
    PIX_HUE_O == 3'h0 |-> PIX_LUMA_O == pbc_pkg::PCT_DARK[PIX_BRT_O])
    else $error("dark grey luminance wrong");
  AST_LIGHT_LADDER: assert property (
    PIX_HUE_O == 3'h7 |-> PIX_LUMA_O == pbc_pkg::PCT_LIGHT[PIX_BRT_O])
    else $error("light grey luminance wrong");
  AST_HUE_LADDER: assert property (
    PIX_CHROMA_O |-> PIX_LUMA_O == pbc_pkg::PCT_CHROMA[PIX_BRT_O])
    else $error("hue luminance wrong");
  // Picture windows always pass live; only border and background areas need a main picture
  AST_NO_MAIN_NO_LIVE: assert property (
    !LIVE_OK_I && AREA_I != 2'h0 |=> !PIX_LIVE_O) else $error("live without main picture");
  // Picks may only move one or two edges after a field start
  AST_PICK_AT_FIELD: assert property (
    $changed(LIVE_SUB_O) || $changed(HILITE_CH_O) |-> $past(FIELD_START_I) ||
    $past(FIELD_START_I, 2)) else $error("pick changed mid field");

  cover property (HILITE_VALID_O);
  cover property (FACTORY_O && !PIX_LIVE_O);
  cover property (PIX_LIVE_O && LIVE_SUB_VALID_O);
endmodule

bind pbc_colour_ctrl pbc_colour_ctrl_chk #(.CHANNELS(CHANNELS)) i_pbc_colour_ctrl_chk (
  .MCLK_I, .NRST_I, .FIELD_START_I, .AREA_I, .SUB_HOLD_I, .LIVE_OK_I, .PIX_LIVE_O, .PIX_BRT_O,
  .PIX_HUE_O, .PIX_LUMA_O, .PIX_CHROMA_O, .LIVE_SUB_O, .LIVE_SUB_VALID_O, .HILITE_CH_O,
  .HILITE_VALID_O, .FACTORY_O);

//--- dv/pbc_host_model.sv
// Two-wire bus host that writes and reads the colour registers.
// Assumes a pulled-up data line; the bus clock is far slower than MCLK.
module pbc_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h45
) (
  input wire logic clk_i,
  input wire logic sda_oe_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic low = 1'b0;
  // Pull-up: released line reads high
  assign sda_o = !(low || sda_oe_i);
  initial scl_o = 1'b1;

  task automatic half();
    repeat (4) @(posedge clk_i);
  endtask
  // Data moves only while the clock is low; ack settles 1 MCLK after the fall
  task automatic bit_io(input logic b, output logic r);
    low <= !b;
    half();
    scl_o <= 1'b1;
    half();
    r = sda_o;
    scl_o <= 1'b0;
    half();
  endtask
  task automatic start();
    low <= 1'b0;
    half();
    scl_o <= 1'b1;
    half();
    low <= 1'b1;
    half();
    scl_o <= 1'b0;
    half();
  endtask
  task automatic stop();
    low <= 1'b1;
    half();
    scl_o <= 1'b1;
    half();
    low <= 1'b0;
    half();
  endtask
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic nak);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(1'b1, nak);
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] val, output int n);
    logic [7:0] q;
    logic a, b, c;
    start();
    byte_io({DEV_ADDR, 1'b0}, q, a);
    byte_io(ofs, q, b);
    byte_io(val, q, c);
    stop();
    n = a + b + c;
  endtask
  // Last byte read is refused by the host, as the bus requires
  task automatic rd(input logic [7:0] ofs, output logic [7:0] q, output int n);
    logic a, b, c;
    start();
    byte_io({DEV_ADDR, 1'b0}, q, a);
    byte_io(ofs, q, b);
    start();
    byte_io({DEV_ADDR, 1'b1}, q, c);
    n = a + b + c;
    byte_io(8'hFF, q, a);
    stop();
  endtask
endmodule

//--- hdl/pbc_colour_ctrl.sv
// Border and background colour control: registers, field-aligned update, area colour.
// Assumes the video path marks field starts and the area and channel of each pixel.
module pbc_colour_ctrl #(
  parameter int CHANNELS = 8,
  parameter logic [6:0] DEV_ADDR = 7'h45
) (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic NRST_I,
  // Serial port
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  // Video timing and state from the rest of the device
  input wire logic FIELD_START_I,
  input wire logic [1:0] AREA_I,
  input wire logic [2:0] CHAN_I,
  input wire logic [CHANNELS-1:0] SHOWN_I,
  input wire logic SUB_HOLD_I,
  input wire logic LIVE_OK_I,
  // Resolved pixel
  output logic PIX_LIVE_O,
  output logic [1:0] PIX_BRT_O,
  output logic [2:0] PIX_HUE_O,
  output logic [6:0] PIX_LUMA_O,
  output logic PIX_CHROMA_O,
  // Channel selections and factory mode flag
  output logic [2:0] LIVE_SUB_O,
  output logic LIVE_SUB_VALID_O,
  output logic [2:0] HILITE_CH_O,
  output logic HILITE_VALID_O,
  output logic FACTORY_O
);

  // Three select bits cannot address more channels
  if (CHANNELS < 1 || CHANNELS > 8) begin : g_chk
    $error("CHANNELS must be between 1 and 8");
  end

  typedef struct packed {
    logic [7:0] sh_sel;
    logic [7:0] sh_mb;
    logic [7:0] sh_sb;
    logic [7:0] sh_cb;
    logic [7:0] sh_bg;
    logic [7:0] ac_sel;
    logic [7:0] ac_mb;
    logic [7:0] ac_sb;
    logic [7:0] ac_cb;
    logic [7:0] ac_bg;
    logic live;
    logic [1:0] brt;
    logic [2:0] hue;
    logic [6:0] luma;
    logic chroma;
    logic [2:0] lsub;
    logic lsub_v;
    logic [2:0] hch;
    logic hch_v;
    logic fac;
  } pbc_ctrl_s;

  pbc_ctrl_s st_ff;
  pbc_ctrl_s nxt_st;

  logic wr;
  logic [7:0] ptr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic sda_oe;
  logic res_live;
  logic [1:0] res_brt;
  logic [2:0] res_col;
  logic [6:0] dec_pct;
  logic dec_chroma;

  function automatic logic f_en(input logic [7:0] r);
    return r[pbc_pkg::EN_BIT];
  endfunction

  function automatic logic [1:0] f_brt(input logic [7:0] r);
    return r[pbc_pkg::BRT_LSB +: 2];
  endfunction

  function automatic logic [2:0] f_col(input logic [7:0] r);
    return r[pbc_pkg::COL_LSB +: 3];
  endfunction

  function automatic logic f_shown(input logic [CHANNELS-1:0] m, input logic [2:0] ch);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < CHANNELS; i++) begin
      if (ch == i[2:0]) begin
        hit = m[i];
      end
    end
    return hit;
  endfunction

  pbc_serial_port #(
    .DEV_ADDR(DEV_ADDR)
  ) u_port (
    .clk_i(MCLK_I),
    .rst_n_i(NRST_I),
    .scl_i(SCL_I),
    .sda_i(SDA_I),
    .sda_oe_o(sda_oe),
    .wr_o(wr),
    .ptr_o(ptr),
    .wdata_o(wdata),
    .rdata_i(rdata)
  );

  pbc_colour_decode u_dec (
    .brt_i(res_brt),
    .col_i(res_col),
    .pct_o(dec_pct),
    .chroma_o(dec_chroma)
  );

  // Reads show what the host wrote, even before the field start applies it
  always_comb begin
    if (ptr == pbc_pkg::OFS_CHAN_SEL) begin
      rdata = st_ff.sh_sel;
    end else if (ptr == pbc_pkg::OFS_MAIN_BRD) begin
      rdata = st_ff.sh_mb;
    end else if (ptr == pbc_pkg::OFS_SUB_BRD) begin
      rdata = st_ff.sh_sb;
    end else if (ptr == pbc_pkg::OFS_CHAN_BRD) begin
      rdata = st_ff.sh_cb;
    end else if (ptr == pbc_pkg::OFS_BACKDROP) begin
      rdata = st_ff.sh_bg;
    end else begin
      rdata = 8'h00;
    end
  end

  // Area resolution on the applied copy
  always_comb begin
    logic bg_on;
    logic fac_on;
    logic [2:0] hl_pick;
    logic hl_hit;
    pbc_pkg::pbc_area_e area;
    logic [7:0] own;
    logic own_on;
    bg_on = f_en(st_ff.ac_bg);
    fac_on = st_ff.ac_bg[pbc_pkg::FAC_BIT] & bg_on;
    hl_pick = st_ff.ac_sel[pbc_pkg::HILITE_LSB +: 3];
    hl_hit = f_en(st_ff.ac_cb) && (CHAN_I == hl_pick) && f_shown(SHOWN_I, hl_pick);
    area = pbc_pkg::pbc_area_e'(AREA_I);
    // Factory mode paints the border areas with the background too
    if (fac_on && area != pbc_pkg::AREA_PIC) begin
      area = pbc_pkg::AREA_BG;
    end
    own = st_ff.ac_bg;
    own_on = bg_on;
    if (area == pbc_pkg::AREA_MAIN) begin
      own = st_ff.ac_mb;
      own_on = f_en(st_ff.ac_mb);
    end else if (area == pbc_pkg::AREA_SUB && hl_hit) begin
      own = st_ff.ac_cb;
      own_on = 1'b1;
    end else if (area == pbc_pkg::AREA_SUB) begin
      // Unhighlighted channel borders share the sub-border treatment
      own = st_ff.ac_sb;
      own_on = f_en(st_ff.ac_sb);
    end
    res_live = 1'b0;
    res_brt = f_brt(own);
    res_col = f_col(own);
    if (area == pbc_pkg::AREA_PIC) begin
      res_live = 1'b1;
    end else if (!own_on && bg_on) begin
      res_brt = f_brt(st_ff.ac_bg);
      res_col = f_col(st_ff.ac_bg);
    end else if (!own_on) begin
      // Live needs a main picture; without one an off area goes black
      res_live = LIVE_OK_I;
      res_brt = pbc_pkg::BRT_BLACK;
      res_col = pbc_pkg::COL_BLACK;
    end
  end

  always_comb begin
    logic [2:0] ls_pick;
    nxt_st = st_ff;
    if (wr) begin
      if (ptr == pbc_pkg::OFS_CHAN_SEL) begin
        nxt_st.sh_sel = wdata & pbc_pkg::SEL_MASK;
      end else if (ptr == pbc_pkg::OFS_MAIN_BRD) begin
        nxt_st.sh_mb = wdata & pbc_pkg::BRD_MASK;
      end else if (ptr == pbc_pkg::OFS_SUB_BRD) begin
        nxt_st.sh_sb = wdata & pbc_pkg::BRD_MASK;
      end else if (ptr == pbc_pkg::OFS_CHAN_BRD) begin
        nxt_st.sh_cb = wdata & pbc_pkg::BRD_MASK;
      end else if (ptr == pbc_pkg::OFS_BACKDROP) begin
        nxt_st.sh_bg = wdata & pbc_pkg::BG_MASK;
      end
    end
    // Copy taken from the shadow as it stands before this cycle's write
    if (FIELD_START_I) begin
      nxt_st.ac_sel = st_ff.sh_sel;
      nxt_st.ac_mb = st_ff.sh_mb;
      nxt_st.ac_sb = st_ff.sh_sb;
      nxt_st.ac_cb = st_ff.sh_cb;
      nxt_st.ac_bg = st_ff.sh_bg;
    end
    nxt_st.live = res_live;
    nxt_st.brt = res_live ? pbc_pkg::BRT_BLACK : res_brt;
    nxt_st.hue = res_live ? pbc_pkg::COL_BLACK : res_col;
    nxt_st.luma = res_live ? 7'h00 : dec_pct;
    nxt_st.chroma = res_live ? 1'b0 : dec_chroma;
    ls_pick = st_ff.ac_sel[pbc_pkg::LIVE_LSB +: 3];
    nxt_st.lsub = ls_pick;
    nxt_st.lsub_v = !SUB_HOLD_I && f_shown(SHOWN_I, ls_pick);
    nxt_st.hch = st_ff.ac_sel[pbc_pkg::HILITE_LSB +: 3];
    nxt_st.hch_v = f_en(st_ff.ac_cb) && f_shown(SHOWN_I, nxt_st.hch);
    nxt_st.fac = st_ff.ac_bg[pbc_pkg::FAC_BIT] & f_en(st_ff.ac_bg);
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      st_ff <= '{sh_sel: pbc_pkg::REG_RST, sh_mb: pbc_pkg::REG_RST,
                 sh_sb: pbc_pkg::REG_RST, sh_cb: pbc_pkg::REG_RST,
                 sh_bg: pbc_pkg::REG_RST, ac_sel: pbc_pkg::REG_RST,
                 ac_mb: pbc_pkg::REG_RST, ac_sb: pbc_pkg::REG_RST,
                 ac_cb: pbc_pkg::REG_RST, ac_bg: pbc_pkg::REG_RST,
                 default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs
  assign SDA_O = 1'b0;
  assign SDA_OE_O = sda_oe;
  assign PIX_LIVE_O = st_ff.live;
  assign PIX_BRT_O = st_ff.brt;
  assign PIX_HUE_O = st_ff.hue;
  assign PIX_LUMA_O = st_ff.luma;
  assign PIX_CHROMA_O = st_ff.chroma;
  assign LIVE_SUB_O = st_ff.lsub;
  assign LIVE_SUB_VALID_O = st_ff.lsub_v;
  assign HILITE_CH_O = st_ff.hch;
  assign HILITE_VALID_O = st_ff.hch_v;
  assign FACTORY_O = st_ff.fac;

endmodule

//--- hdl/pbc_colour_decode.sv
// Colour code decoder: brightness step and colour code to luminance percent.
// Assumes a purely combinational use; the caller registers the result.
module pbc_colour_decode (
  // Code
  input wire logic [1:0] brt_i,
  input wire logic [2:0] col_i,
  // Result
  output logic [6:0] pct_o,
  output logic chroma_o
);

  always_comb begin
    chroma_o = 1'b1;
    pct_o = pbc_pkg::PCT_CHROMA[brt_i];
    // Codes 0 and 7 are grey ladders with their own levels
    if (col_i == pbc_pkg::COL_DARK) begin
      chroma_o = 1'b0;
      pct_o = pbc_pkg::PCT_DARK[brt_i];
    end else if (col_i == pbc_pkg::COL_LIGHT) begin
      chroma_o = 1'b0;
      pct_o = pbc_pkg::PCT_LIGHT[brt_i];
    end
  end

endmodule

//--- hdl/pbc_pkg.sv
// Shared constants of the border and background colour control block.
// Assumes a single 50 MHz clock and byte-wide registers behind a two-wire serial port.
package pbc_pkg;

  // Register offsets
  localparam logic [7:0] OFS_CHAN_SEL = 8'h05;
  localparam logic [7:0] OFS_MAIN_BRD = 8'h06;
  localparam logic [7:0] OFS_SUB_BRD = 8'h07;
  localparam logic [7:0] OFS_CHAN_BRD = 8'h08;
  localparam logic [7:0] OFS_BACKDROP = 8'h09;

  // Field positions
  localparam int HILITE_LSB = 4;
  localparam int LIVE_LSB = 0;
  localparam int EN_BIT = 6;
  localparam int FAC_BIT = 7;
  localparam int BRT_LSB = 4;
  localparam int COL_LSB = 0;

  // Writable bits; the rest read as zero
  localparam logic [7:0] SEL_MASK = 8'h77;
  localparam logic [7:0] BRD_MASK = 8'h77;
  localparam logic [7:0] BG_MASK = 8'hF7;
  localparam logic [7:0] REG_RST = 8'h00;

  // Grey and black colour codes, and the black brightness step
  localparam logic [2:0] COL_DARK = 3'h0;
  localparam logic [2:0] COL_LIGHT = 3'h7;
  localparam logic [2:0] COL_BLACK = 3'h0;
  localparam logic [1:0] BRT_BLACK = 2'h0;

  // Luminance in percent per brightness step, step 0 in the low slot
  localparam logic [3:0][6:0] PCT_DARK = {7'h32, 7'h1E, 7'h0A, 7'h00};
  localparam logic [3:0][6:0] PCT_LIGHT = {7'h64, 7'h50, 7'h46, 7'h3C};
  localparam logic [3:0][6:0] PCT_CHROMA = {7'h64, 7'h46, 7'h32, 7'h1E};

  // Screen area under the current pixel
  typedef enum logic [1:0] {
    AREA_PIC = 2'h0,
    AREA_MAIN = 2'h1,
    AREA_SUB = 2'h2,
    AREA_BG = 2'h3
  } pbc_area_e;

  // Serial port states
  typedef enum logic [4:0] {
    SP_IDLE = 5'h01,
    SP_RX = 5'h02,
    SP_ACK = 5'h04,
    SP_TX = 5'h08,
    SP_RACK = 5'h10
  } pbc_sp_e;

  // Kind of byte being received
  typedef enum logic [1:0] {
    K_ADDR = 2'h0,
    K_SUB = 2'h1,
    K_DATA = 2'h2
  } pbc_kind_e;

  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] PTR_STEP = 8'h01;

endpackage

//--- hdl/pbc_serial_port.sv
// Two-wire serial slave: device address, subaddress, then data with auto-increment.
// Assumes SCL and SDA are already synchronous to the clock and slow against it.
module pbc_serial_port #(
  parameter logic [6:0] DEV_ADDR = 7'h45
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Serial pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe_o,
  // Register access
  output logic wr_o,
  output logic [7:0] ptr_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i
);

  typedef struct packed {
    pbc_pkg::pbc_sp_e st;
    pbc_pkg::pbc_kind_e kind;
    logic rw;
    logic full;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic scl;
    logic sda;
    logic wr;
    logic oe;
  } pbc_sp_s;

  pbc_sp_s st_ff;
  pbc_sp_s nxt_st;
  logic rise;
  logic fall;

  assign rise = scl_i & ~st_ff.scl;
  assign fall = ~scl_i & st_ff.scl;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.scl = scl_i;
    nxt_st.sda = sda_i;
    nxt_st.wr = 1'b0;
    if (scl_i && st_ff.scl && st_ff.sda && !sda_i) begin
      nxt_st.st = pbc_pkg::SP_RX;
      nxt_st.kind = pbc_pkg::K_ADDR;
      nxt_st.cnt = 3'h0;
      nxt_st.full = 1'b0;
    end else if (scl_i && st_ff.scl && !st_ff.sda && sda_i) begin
      nxt_st.st = pbc_pkg::SP_IDLE;
    end else begin
      case (st_ff.st)
        pbc_pkg::SP_RX: begin
          if (rise) begin
            nxt_st.sh = {st_ff.sh[6:0], sda_i};
            nxt_st.cnt = st_ff.cnt + 3'h1;
            nxt_st.full = (st_ff.cnt == pbc_pkg::BIT_LAST);
          end else if (fall && st_ff.full) begin
            nxt_st.full = 1'b0;
            nxt_st.st = pbc_pkg::SP_ACK;
            if (st_ff.kind == pbc_pkg::K_ADDR) begin
              nxt_st.rw = st_ff.sh[0];
              if (st_ff.sh[7:1] != DEV_ADDR) begin
                nxt_st.st = pbc_pkg::SP_IDLE;
              end
            end else if (st_ff.kind == pbc_pkg::K_SUB) begin
              nxt_st.ptr = st_ff.sh;
            end else begin
              nxt_st.wr = 1'b1;
            end
          end
        end
        pbc_pkg::SP_ACK: begin
          if (fall) begin
            if (st_ff.kind == pbc_pkg::K_DATA) begin
              nxt_st.ptr = st_ff.ptr + pbc_pkg::PTR_STEP;
            end
            if (st_ff.kind == pbc_pkg::K_ADDR && st_ff.rw) begin
              nxt_st.st = pbc_pkg::SP_TX;
              nxt_st.sh = rdata_i;
            end else begin
              nxt_st.st = pbc_pkg::SP_RX;
              nxt_st.kind = (st_ff.kind == pbc_pkg::K_ADDR) ? pbc_pkg::K_SUB : pbc_pkg::K_DATA;
            end
          end
        end
        pbc_pkg::SP_TX: begin
          if (fall) begin
            nxt_st.sh = {st_ff.sh[6:0], 1'b0};
            nxt_st.cnt = st_ff.cnt + 3'h1;
            if (st_ff.cnt == pbc_pkg::BIT_LAST) begin
              nxt_st.st = pbc_pkg::SP_RACK;
              nxt_st.ptr = st_ff.ptr + pbc_pkg::PTR_STEP;
            end
          end
        end
        pbc_pkg::SP_RACK: begin
          if (rise && sda_i) begin
            nxt_st.st = pbc_pkg::SP_IDLE;
          end else if (fall) begin
            nxt_st.st = pbc_pkg::SP_TX;
            nxt_st.sh = rdata_i;
          end
        end
        default: begin
          nxt_st.st = pbc_pkg::SP_IDLE;
        end
      endcase
    end
    // Open drain: only ever pull low
    nxt_st.oe = (nxt_st.st == pbc_pkg::SP_ACK) || (nxt_st.st == pbc_pkg::SP_TX && !nxt_st.sh[7]);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '{st: pbc_pkg::SP_IDLE, kind: pbc_pkg::K_ADDR, scl: 1'b1, sda: 1'b1,
                 default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sda_oe_o = st_ff.oe;
  assign wr_o = st_ff.wr;
  assign ptr_o = st_ff.ptr;
  assign wdata_o = st_ff.sh;

endmodule
